/* File: src/blru_cfg.svh */
`ifndef BLRU_CFG_SVH
`define BLRU_CFG_SVH

`define BLRU_ADDR_W      8
`define BLRU_NEST_DEPTH  8
`define BLRU_DEPTH_W     4
`define BLRU_IDX_W       3
`define BLRU_RESULT_RST  1'b0
`define BLRU_FIRST_RST   1'b1

`endif

/* File: src/blru_pkg.sv */
`include "blru_cfg.svh"

package blru_pkg;

	// operation codes seen on the instruction port
	typedef enum logic [3:0] {
		BLRU_OP_NO_OPERATION_FILLER,
		BLRU_OP_AND_SCAN,
		BLRU_OP_AND_NOT_SCAN,
		BLRU_OP_OR_SCAN,
		BLRU_OP_OR_NOT_SCAN,
		BLRU_OP_OR_GROUP,
		BLRU_OP_AND_OPEN,
		BLRU_OP_OR_OPEN,
		BLRU_OP_CLOSE,
		BLRU_OP_SET,
		BLRU_OP_RESET,
		BLRU_OP_ASSIGN
	} blru_op_e;

	// saved context of one open bracket
	typedef struct packed {
		logic result;
		logic or_acc;
		logic first;
		logic is_or;
	} blru_frame_s;

	typedef logic [`BLRU_ADDR_W-1:0] blru_addr_t;

endpackage : blru_pkg

/* File: src/blru_bitmem_if.sv */
`timescale 1ns/1ps
`default_nettype none

interface blru_bitmem_if;
	blru_pkg::blru_addr_t rd_addr;
	logic                 rd_bit;
	logic                 st_we;
	blru_pkg::blru_addr_t st_addr;
	logic                 st_bit;
	logic                 img_we;
	blru_pkg::blru_addr_t img_addr;
	logic                 img_bit;

	modport ctrl (output rd_addr, input rd_bit, output st_we, output st_addr, output st_bit,
		output img_we, output img_addr, output img_bit);
	modport mem (input rd_addr, output rd_bit, input st_we, input st_addr, input st_bit,
		input img_we, input img_addr, input img_bit);
endinterface : blru_bitmem_if

`default_nettype wire

/* File: src/blru_bitmem.sv */
`timescale 1ns/1ps
`default_nettype none

`include "blru_cfg.svh"

module blru_bitmem (
	input  wire logic      i_core_clk,
	input  wire logic      i_rst,
	blru_bitmem_if.mem     bus
);
	logic bits [0:(1<<`BLRU_ADDR_W)-1];

	// operand image; a store in the same cycle as an image update wins
	always_ff @(posedge i_core_clk) begin
		if (bus.img_we) begin
			bits[bus.img_addr] <= bus.img_bit;
		end
		if (bus.st_we) begin
			bits[bus.st_addr] <= bus.st_bit;
		end
	end

	// registered read port
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			bus.rd_bit <= 1'b0;
		end else begin
			bus.rd_bit <= bits[bus.rd_addr];
		end
	end
endmodule : blru_bitmem

`default_nettype wire

/* File: src/blru_unit.sv */
`timescale 1ns/1ps
`default_nettype none

`include "blru_cfg.svh"

module blru_unit (
	input  wire logic                     i_core_clk,
	input  wire logic                     i_rst,
	input  wire logic                     i_instr_valid,
	input  wire blru_pkg::blru_op_e       i_instr_op,
	input  wire blru_pkg::blru_addr_t     i_instr_addr,
	input  wire logic                     i_img_we,
	input  wire blru_pkg::blru_addr_t     i_img_addr,
	input  wire logic                     i_img_bit,
	output logic                          o_logic_result_bit,
	output logic                          o_first_scan,
	output logic                          o_retire,
	output logic                          o_store_valid,
	output blru_pkg::blru_addr_t          o_store_addr,
	output logic                          o_store_bit,
	output logic [`BLRU_DEPTH_W-1:0]      o_nest_depth,
	output logic                          o_nest_error
);
	blru_bitmem_if mem_bus ();

	blru_bitmem u_mem (
		.i_core_clk (i_core_clk),
		.i_rst      (i_rst),
		.bus        (mem_bus)
	);

	// operation state
	logic                    logic_result_bit;
	logic                    or_acc;
	logic                    first;
	blru_pkg::blru_frame_s   stack [`BLRU_NEST_DEPTH];
	logic [`BLRU_DEPTH_W-1:0] depth;
	// pipeline stage holding the operation whose operand is being read
	logic                    s1_valid;
	blru_pkg::blru_op_e      s1_op;
	blru_pkg::blru_addr_t    s1_addr;
	// last real store, forwarded past the one-cycle read latency
	logic                    fwd_valid;
	blru_pkg::blru_addr_t    fwd_addr;
	logic                    fwd_bit;

	logic                    scan_bit;
	logic                    eff;
	logic [`BLRU_IDX_W-1:0]  top_idx;
	blru_pkg::blru_frame_s   top;
	logic                    stack_full;
	logic                    stack_empty;
	logic                    next_result;
	logic                    next_or_acc;
	logic                    next_first;
	logic                    do_push;
	logic                    do_pop;
	logic                    nest_fault;
	logic                    st_we;
	logic                    st_bit;
	logic                    inner;
	logic                    op_val;

	// operand read is launched as the operation is accepted
	assign mem_bus.rd_addr  = i_instr_addr;
	assign mem_bus.img_we   = i_img_we;
	assign mem_bus.img_addr = i_img_addr;
	assign mem_bus.img_bit  = i_img_bit;
	assign mem_bus.st_we    = st_we;
	assign mem_bus.st_addr  = s1_addr;
	assign mem_bus.st_bit   = st_bit;

	// forwarding avoids reading a stale bit right after a store to it
	assign scan_bit    = (fwd_valid && fwd_addr == s1_addr) ? fwd_bit : mem_bus.rd_bit;
	assign eff         = or_acc | logic_result_bit;
	assign top_idx     = depth[`BLRU_IDX_W-1:0] - {{(`BLRU_IDX_W-1){1'b0}}, 1'b1};
	assign top         = stack[top_idx];
	assign stack_full  = (depth == `BLRU_DEPTH_W'(`BLRU_NEST_DEPTH));
	assign stack_empty = (depth == '0);
	assign inner       = eff;

	// next value of the result, the group accumulator and the first-scan flag
	always_comb begin
		next_result = logic_result_bit;
		next_or_acc = or_acc;
		next_first  = first;
		do_push     = 1'b0;
		do_pop      = 1'b0;
		nest_fault  = 1'b0;
		st_we       = 1'b0;
		st_bit      = 1'b0;
		op_val      = scan_bit;
		if (s1_valid) begin
			case (s1_op)
				blru_pkg::BLRU_OP_AND_SCAN, blru_pkg::BLRU_OP_AND_NOT_SCAN: begin
					op_val      = (s1_op == blru_pkg::BLRU_OP_AND_SCAN) ? scan_bit : ~scan_bit;
					next_result = first ? op_val : (logic_result_bit & op_val);
					next_first  = 1'b0;
				end
				blru_pkg::BLRU_OP_OR_SCAN, blru_pkg::BLRU_OP_OR_NOT_SCAN: begin
					op_val      = (s1_op == blru_pkg::BLRU_OP_OR_SCAN) ? scan_bit : ~scan_bit;
					next_result = first ? op_val : (logic_result_bit | op_val);
					next_first  = 1'b0;
				end
				blru_pkg::BLRU_OP_OR_GROUP: begin
					next_or_acc = eff;
					next_first  = 1'b1;
				end
				blru_pkg::BLRU_OP_AND_OPEN, blru_pkg::BLRU_OP_OR_OPEN: begin
					if (stack_full) begin
						nest_fault = 1'b1;
					end else begin
						do_push     = 1'b1;
						next_or_acc = 1'b0;
						next_first  = 1'b1;
					end
				end
				blru_pkg::BLRU_OP_CLOSE: begin
					if (stack_empty) begin
						nest_fault = 1'b1;
					end else begin
						do_pop      = 1'b1;
						next_or_acc = top.or_acc;
						next_first  = 1'b0;
						if (top.first) begin
							next_result = inner;
						end else if (top.is_or) begin
							next_result = top.result | inner;
						end else begin
							next_result = top.result & inner;
						end
					end
				end
				blru_pkg::BLRU_OP_SET, blru_pkg::BLRU_OP_RESET, blru_pkg::BLRU_OP_ASSIGN: begin
					// stores limit the result: the next scan starts a new chain
					st_we       = (s1_op == blru_pkg::BLRU_OP_ASSIGN) | eff;
					st_bit      = (s1_op != blru_pkg::BLRU_OP_RESET) &
						((s1_op != blru_pkg::BLRU_OP_ASSIGN) | eff);
					next_result = eff;
					next_or_acc = 1'b0;
					next_first  = 1'b1;
				end
				default: begin
					next_result = logic_result_bit;
				end
			endcase
		end
	end

	// result and group state; one operation retires per cycle
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			logic_result_bit <= `BLRU_RESULT_RST;
			or_acc           <= 1'b0;
			first            <= `BLRU_FIRST_RST;
		end else begin
			logic_result_bit <= next_result;
			or_acc           <= next_or_acc;
			first            <= next_first;
		end
	end

	// bracket stack; entries need no reset since depth guards them
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			depth <= '0;
		end else if (do_push) begin
			stack[depth[`BLRU_IDX_W-1:0]] <= '{result: logic_result_bit, or_acc: or_acc,
				first: first, is_or: (s1_op == blru_pkg::BLRU_OP_OR_OPEN)};
			depth <= depth + `BLRU_DEPTH_W'(1);
		end else if (do_pop) begin
			depth <= depth - `BLRU_DEPTH_W'(1);
		end
	end

	// accept stage
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			s1_valid <= 1'b0;
			s1_op    <= blru_pkg::BLRU_OP_NO_OPERATION_FILLER;
			s1_addr  <= '0;
		end else begin
			s1_valid <= i_instr_valid;
			s1_op    <= i_instr_op;
			s1_addr  <= i_instr_addr;
		end
	end

	// store forwarding; later store overwrites, so the last in sequence wins
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			fwd_valid <= 1'b0;
			fwd_addr  <= '0;
			fwd_bit   <= 1'b0;
		end else begin
			fwd_valid <= st_we;
			fwd_addr  <= s1_addr;
			fwd_bit   <= st_bit;
		end
	end

	// registered outputs
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			o_store_valid <= 1'b0;
			o_store_addr  <= '0;
			o_store_bit   <= 1'b0;
			o_retire      <= 1'b0;
			o_nest_error  <= 1'b0;
		end else begin
			o_store_valid <= st_we;
			o_store_addr  <= s1_addr;
			o_store_bit   <= st_bit;
			o_retire      <= s1_valid;
			o_nest_error  <= o_nest_error | nest_fault; // sticky until reset
		end
	end

	assign o_logic_result_bit = logic_result_bit;
	assign o_first_scan       = first;
	assign o_nest_depth       = depth;

	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (i_rst);

	sequence s_scan(blru_pkg::blru_op_e op);
		s1_valid && s1_op == op;
	endsequence

	sequence s_set_true;
		s1_valid && s1_op == blru_pkg::BLRU_OP_SET && eff;
	endsequence

	and_chain_a : assert property (s_scan(blru_pkg::BLRU_OP_AND_SCAN) and !first && !scan_bit
		|=> !logic_result_bit) else $error("and scan of zero left result high");
	or_chain_a : assert property (s_scan(blru_pkg::BLRU_OP_OR_SCAN) and scan_bit
		|=> logic_result_bit) else $error("or scan of one left result low");
	first_load_a : assert property (s_scan(blru_pkg::BLRU_OP_AND_SCAN) and first
		|=> logic_result_bit == $past(scan_bit) && !first) else $error("first scan not loaded");
	set_store_a : assert property (s_set_true |=> o_store_valid && o_store_bit
		&& fwd_valid && fwd_bit) else $error("set did not write one");
	reset_store_a : assert property (s_scan(blru_pkg::BLRU_OP_RESET) and eff
		|=> o_store_valid && !o_store_bit) else $error("reset did not write zero");
	assign_store_a : assert property (s_scan(blru_pkg::BLRU_OP_ASSIGN)
		|=> o_store_valid && o_store_bit == $past(eff)) else $error("assign wrong value");
	paren_and_a : assert property (s_scan(blru_pkg::BLRU_OP_CLOSE) and !stack_empty
		&& !top.first && !top.is_or
		|=> logic_result_bit == $past(top.result & inner)) else $error("bracket and wrong");
	or_group_a : assert property (s_scan(blru_pkg::BLRU_OP_OR_GROUP)
		|=> first && or_acc == $past(eff)) else $error("or group not accumulated");
	hold_set_a : assert property (s_scan(blru_pkg::BLRU_OP_SET) and !eff
		|=> !o_store_valid) else $error("set with false result wrote bit");
	retire_a : assert property (s1_valid |=> o_retire)
		else $error("operation not retired next cycle");
endmodule : blru_unit

`default_nettype wire

/* File: tb/bit_logic_result_unit_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "blru_cfg.svh"

module bit_logic_result_unit_tb;
	typedef struct packed {
		logic                 chk;
		logic                 res;
		logic                 first;
		logic                 sv;
		blru_pkg::blru_addr_t sa;
		logic                 sb;
		logic [3:0]           dep;
	} blru_note_s;

	logic                         i_core_clk;
	logic                         i_rst;
	logic                         i_instr_valid;
	blru_pkg::blru_op_e           i_instr_op;
	blru_pkg::blru_addr_t         i_instr_addr;
	logic                         i_img_we;
	blru_pkg::blru_addr_t         i_img_addr;
	logic                         i_img_bit;
	logic                         o_logic_result_bit;
	logic                         o_first_scan;
	logic                         o_retire;
	logic                         o_store_valid;
	blru_pkg::blru_addr_t         o_store_addr;
	logic                         o_store_bit;
	logic [`BLRU_DEPTH_W-1:0]     o_nest_depth;
	logic                         o_nest_error;

	int                           error_cnt = 0;
	int                           checks = 0;
	int                           seed = 66;
	int                           cyc = 0;
	int                           sp = 0;
	logic                         quiet = 1'b0;
	logic [1:0]                   pipe = 2'h0;
	logic                         m_res, m_first, m_or;
	logic                         mem [256];
	blru_pkg::blru_frame_s        stk [8];
	blru_note_s                   q [$];
	// directed program; the last entry is a filler that must leave all state alone
	logic [15:0]                  dir [15] = '{16'h0101, 16'h0920, 16'h0100, 16'h0920, 16'h0100,
		16'h0A20, 16'h0120, 16'h0B21, 16'h0102, 16'h0A20, 16'h0101, 16'h0920, 16'h0102, 16'h0B22,
		16'h0000};

	blru_unit blru_unit_inst (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_instr_valid(i_instr_valid),
		.i_instr_op(i_instr_op), .i_instr_addr(i_instr_addr), .i_img_we(i_img_we),
		.i_img_addr(i_img_addr), .i_img_bit(i_img_bit), .o_logic_result_bit(o_logic_result_bit),
		.o_first_scan(o_first_scan), .o_retire(o_retire), .o_store_valid(o_store_valid),
		.o_store_addr(o_store_addr), .o_store_bit(o_store_bit), .o_nest_depth(o_nest_depth),
		.o_nest_error(o_nest_error));

	// free-running clock, 10 ns period
	initial begin
		i_core_clk = 1'b0;
		forever #5 i_core_clk = ~i_core_clk;
	end

	task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
		checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH %s expected %0h seen %0h", nm, exp, got);
		end
	endtask : chk

	task automatic close_out;
		$display("checks %0d errors %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : close_out

	// one operation per falling edge; valid stays up so back-to-back calls never toggle it
	task automatic drive(input blru_pkg::blru_op_e op, input blru_pkg::blru_addr_t a);
		i_instr_valid = 1'b1;
		i_instr_op    = op;
		i_instr_addr  = a;
		@(negedge i_core_clk);
	endtask : drive

	// ends a burst of operations; called only after a drive has let its edge pass
	task automatic idle;
		i_instr_valid = 1'b0;
		i_instr_op    = blru_pkg::BLRU_OP_NO_OPERATION_FILLER;
	endtask : idle

	// reference behaviour; notes only what is defined at the ports for each kind
	task automatic issue(input blru_pkg::blru_op_e op, input blru_pkg::blru_addr_t a);
		logic v;
		logic e;
		blru_note_s n;
		v = mem[a];
		n = '0;
		e = m_or | m_res;
		case (op)
			blru_pkg::BLRU_OP_AND_SCAN, blru_pkg::BLRU_OP_AND_NOT_SCAN,
			blru_pkg::BLRU_OP_OR_SCAN, blru_pkg::BLRU_OP_OR_NOT_SCAN: begin
				if (op == blru_pkg::BLRU_OP_AND_NOT_SCAN || op == blru_pkg::BLRU_OP_OR_NOT_SCAN) v = ~v;
				if (m_first) m_res = v;
				else if (op <= blru_pkg::BLRU_OP_AND_NOT_SCAN) m_res = m_res & v;
				else m_res = m_res | v;
				m_first = 1'b0;
				n.chk = 1'b1;
			end
			blru_pkg::BLRU_OP_OR_GROUP: begin
				m_or = e;
				m_first = 1'b1;
			end
			blru_pkg::BLRU_OP_AND_OPEN, blru_pkg::BLRU_OP_OR_OPEN: begin
				stk[sp] = '{m_res, m_or, m_first, op == blru_pkg::BLRU_OP_OR_OPEN};
				sp++;
				m_first = 1'b1;
				m_or = 1'b0;
			end
			blru_pkg::BLRU_OP_CLOSE: begin
				sp--;
				m_res = stk[sp].first ? e : stk[sp].is_or ? stk[sp].result | e : stk[sp].result & e;
				m_or = stk[sp].or_acc;
				m_first = 1'b0;
			end
			blru_pkg::BLRU_OP_NO_OPERATION_FILLER: begin
				n.chk = 1'b1; // filler keeps result and first-scan as they are
			end
			default: begin
				n.sv = op == blru_pkg::BLRU_OP_ASSIGN || e;
				n.sa = a;
				n.sb = op == blru_pkg::BLRU_OP_SET ? 1'b1 : op == blru_pkg::BLRU_OP_RESET ? 1'b0 : e;
				if (n.sv) mem[a] = n.sb;
				m_res = e;
				m_first = 1'b1;
				m_or = 1'b0;
				n.chk = 1'b1;
			end
		endcase
		n.res = m_res;
		n.first = m_first;
		n.dep = 4'(sp);
		q.push_back(n);
		drive(op, a);
	endtask : issue

	task automatic do_reset(input int n);
		i_rst = 1'b1;
		repeat (n) @(negedge i_core_clk);
		i_rst = 1'b0;
		{m_res, m_first, m_or, sp} = {3'b010, 32'd0};
		chk("result", 8'h00, 8'(o_logic_result_bit));
		chk("first", 8'h01, 8'(o_first_scan));
		chk("depth", 8'h00, 8'(o_nest_depth));
		chk("nest_err", 8'h00, 8'(o_nest_error));
		@(negedge i_core_clk);
	endtask : do_reset

	// random bracketed expression ending in one store
	task automatic rand_prog(input int len);
		int d;
		logic need;
		logic [31:0] r;
		need = 1'b1;
		d = 0;
		for (int k = 0; k < len; k++) begin
			r = $random(seed);
			if (need || r[2:0] < 3'h3) begin
				issue(blru_pkg::blru_op_e'(4'h1 + r[4:3]), blru_pkg::blru_addr_t'(r[12:8]));
				need = 1'b0;
			end else if (r[2:0] == 3'h3) begin
				issue(blru_pkg::BLRU_OP_OR_GROUP, 8'h00);
				need = 1'b1;
			end else if (r[2:0] == 3'h4 && d < 3) begin
				issue(r[5] ? blru_pkg::BLRU_OP_AND_OPEN : blru_pkg::BLRU_OP_OR_OPEN, 8'h00);
				d++;
				need = 1'b1;
			end else if (d > 0) begin
				issue(blru_pkg::BLRU_OP_CLOSE, 8'h00);
				d--;
			end
		end
		for (; d > 0; d--) issue(blru_pkg::BLRU_OP_CLOSE, 8'h00);
		r = $random(seed);
		issue(blru_pkg::blru_op_e'(4'h9 + 4'(r[17:16] % 3)), 8'h10 + 8'(r[19:16]));
	endtask : rand_prog

	// retire expected exactly one edge after acceptance
	always @(posedge i_core_clk) pipe <= {pipe[0], i_instr_valid & ~i_rst};

	// watcher: each retire takes the oldest note
	always @(negedge i_core_clk) begin
		blru_note_s n;
		if (!quiet) begin
			chk("retire", 8'(pipe[1]), 8'(o_retire));
			if (o_retire === 1'b1 && q.size() > 0) begin
				n = q.pop_front();
				chk("store_valid", 8'(n.sv), 8'(o_store_valid));
				if (n.sv) chk("store_addr", n.sa, o_store_addr);
				if (n.sv) chk("store_bit", 8'(n.sb), 8'(o_store_bit));
				if (n.chk) chk("result", 8'(n.res), 8'(o_logic_result_bit));
				if (n.chk) chk("first", 8'(n.first), 8'(o_first_scan));
				chk("depth", 8'(n.dep), 8'(o_nest_depth));
			end
		end
	end

	// hang guard, well beyond the expected run length
	always @(posedge i_core_clk) begin
		cyc++;
		if (cyc == 30000) begin
			error_cnt++;
			close_out();
		end
	end

	initial begin
		{i_instr_valid, i_img_we, i_img_bit, i_instr_addr, i_img_addr} = '0;
		i_instr_op = blru_pkg::BLRU_OP_NO_OPERATION_FILLER;
		do_reset(16);
		// image not reset, so fill bits 0 to 31 first; scanned bit 0x20 is set by the directed program
		for (int a = 0; a < 32; a++) begin
			{i_img_we, i_img_addr, i_img_bit} = {1'b1, 8'(a), (a == 1 || a == 2) ? 1'b1 :
				a == 0 ? 1'b0 : 1'($random(seed))};
			mem[a] = i_img_bit;
			@(negedge i_core_clk);
		end
		i_img_we = 1'b0;
		for (int k = 0; k < 15; k++) issue(blru_pkg::blru_op_e'(dir[k][11:8]), dir[k][7:0]);
		for (int k = 0; k < 200; k++) rand_prog(3 + k % 9);
		idle();
		repeat (4) @(negedge i_core_clk);
		chk("queue", 8'h00, 8'(q.size()));
		quiet = 1'b1;
		// nine opens: the ninth is refused, depth stays at eight
		for (int k = 0; k < 9; k++) drive(blru_pkg::BLRU_OP_AND_OPEN, 8'h00);
		idle();
		repeat (3) @(negedge i_core_clk);
		chk("depth", 8'h08, 8'(o_nest_depth));
		chk("nest_err", 8'h01, 8'(o_nest_error));
		do_reset(2);
		drive(blru_pkg::BLRU_OP_CLOSE, 8'h00);
		idle();
		repeat (3) @(negedge i_core_clk);
		chk("depth", 8'h00, 8'(o_nest_depth));
		chk("nest_err", 8'h01, 8'(o_nest_error));
		close_out();
	end
endmodule : bit_logic_result_unit_tb

`default_nettype wire
